/* rtl/hcc_pkg.sv */
// Purpose: Shared constants and types for the hysteresis chopper sequencer
// Assumes: One instance per coil, system clock of 250 MHz
// Notes:   Hysteresis values are signed; effective end may go negative
package hcc_pkg;
	// Field widths
	localparam int OFF_TIME_W   = 4;   // Off-time setting width
	localparam int HYST_START_W = 3;   // Start offset field width
	localparam int HYST_END_W   = 4;   // End value field width
	localparam int HYST_W       = 6;   // Signed working hysteresis width
	localparam int CNT_W        = 10;  // Phase timer width
	// Timing counts in system clocks
	localparam logic [CNT_W-1:0] SLOW_BASE_CLKS  = 10'h00C; // Base length
	localparam logic [CNT_W-1:0] SLOW_STEP_CLKS  = 10'h020; // Per setting
	localparam logic [3:0]       HYSTERESIS_DECREMENTER_PERIOD     = 4'hF;    // 16 clocks - 1
	// Field offsets
	localparam logic [HYST_W-1:0] HYST_START_ADD = 6'h01;   // Start + 1
	localparam logic [HYST_W-1:0] HYST_END_SUB   = 6'h03;   // End - 3
	// Blank time table in clocks, indexed by setting
	localparam logic [CNT_W-1:0] BLANK_CLKS_0 = 10'h010;
	localparam logic [CNT_W-1:0] BLANK_CLKS_1 = 10'h018;
	localparam logic [CNT_W-1:0] BLANK_CLKS_2 = 10'h024;
	localparam logic [CNT_W-1:0] BLANK_CLKS_3 = 10'h036;

	// Chopper phases
	typedef enum logic [2:0] {
		HCC_IDLE, HCC_ON, HCC_SLOW1, HCC_FAST, HCC_SLOW2
	} hcc_phase_t;

	// Configuration carried as one group
	typedef struct packed {
		logic                    mode_sel;                // 0 = this chopper
		logic [OFF_TIME_W-1:0]   off_time_setting;
		logic [HYST_START_W-1:0] hysteresis_start_offset;
		logic [HYST_END_W-1:0]   hysteresis_end_value;
		logic [1:0]              comparator_blank_time;
	} hcc_cfg_t;

	// Bridge drive group
	typedef struct packed {
		logic high_a;  // High side, positive leg
		logic low_a;   // Low side, positive leg
		logic high_b;  // High side, negative leg
		logic low_b;   // Low side, negative leg
	} hcc_bridge_t;
endpackage

/* rtl/hcc_chopper.sv */
// Purpose: Four-phase hysteresis chopper sequencer for one coil
// Assumes: Comparator input is asynchronous; config stable in cycle
// Notes:   Constant off-time mode is external; this block idles then
//
// Functional notes
// [R1] Phases: on, slow, fast, slow, repeat
// [R2] Fast decay ends on comparator result
// [R3] Slow decay lasts 12 plus 32 times setting
// [R4] Comparator masked during blank time after switching
// [R5] Cycle start loads start plus end hysteresis
// [R6] Decrement every 16 clocks down to end
// [R7] Effective start offset is field plus one
// [R8] Effective end value is field minus three
// [R9] Host keeps start plus end at most 16
// [R10] Off-time zero switches all transistors off
// [R11] Mode bit zero selects this chopper
// [R12] On ends at target+hyst, fast at target-hyst
`timescale 1ns/10ps
`default_nettype none
module hcc_chopper
	import hcc_pkg::*;
(
	input  wire logic         mclk_i,        // System clock
	input  wire logic         rst_n_i,       // Async reset, active low
	input  wire hcc_cfg_t     cfg_i,         // Chopper configuration
	input  wire logic         cmp_above_i,   // Current above upper threshold
	input  wire logic         cmp_below_i,   // Current below lower threshold
	output hcc_bridge_t       bridge_o,      // Bridge switch drive
	output logic signed [HYST_W-1:0] hyst_o, // Working hysteresis
	output logic              cycle_start_o, // Pulse at cycle start
	output hcc_phase_t        phase_o        // Current phase
);
	// Assertions below share this clock and reset
	default clocking sva_clk @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Comparator synchronisers, three stages each
	logic [2:0] above_sync_reg;
	logic [2:0] below_sync_reg;
	logic       above_reg;   // Filtered comparator level
	logic       below_reg;
	// Sequencer state
	hcc_phase_t            phase_reg;
	hcc_phase_t            phase_next;
	logic [CNT_W-1:0]      timer_reg;     // Phase or blank timer
	logic [3:0]            hysteresis_decrementer_reg;      // Decrement prescaler
	logic signed [HYST_W-1:0] hyst_reg;
	logic                  enable;
	logic                  blanked;
	logic                  phase_done;
	logic [CNT_W-1:0]      slow_clks;
	logic [CNT_W-1:0]      blank_clks;
	logic signed [HYST_W-1:0] eff_start;
	logic signed [HYST_W-1:0] eff_end;

	// Mode and off-time gate the whole chopper
	assign enable = !cfg_i.mode_sel                              // [R11]
		&& (cfg_i.off_time_setting != '0);                   // [R10]

	// Slow decay length in clocks
	assign slow_clks = SLOW_BASE_CLKS                            // [R3]
		+ CNT_W'(SLOW_STEP_CLKS * CNT_W'(cfg_i.off_time_setting));

	// Effective hysteresis bounds
	assign eff_start = HYST_W'(cfg_i.hysteresis_start_offset)
		+ HYST_START_ADD;                                    // [R7]
	assign eff_end = HYST_W'(cfg_i.hysteresis_end_value)
		- HYST_END_SUB;                                      // [R8]

	// Blank time lookup
	always_comb begin
		unique case (cfg_i.comparator_blank_time)
			2'h0: blank_clks = BLANK_CLKS_0;
			2'h1: blank_clks = BLANK_CLKS_1;
			2'h2: blank_clks = BLANK_CLKS_2;
			default: blank_clks = BLANK_CLKS_3;
		endcase
	end

	// Synchronise comparator outputs
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			above_sync_reg <= 3'h0;
			below_sync_reg <= 3'h0;
		end else begin
			above_sync_reg <= {above_sync_reg[1:0], cmp_above_i};
			below_sync_reg <= {below_sync_reg[1:0], cmp_below_i};
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			above_reg <= 1'b0;
			below_reg <= 1'b0;
		end else begin
			if (above_sync_reg[2] == above_sync_reg[1]) begin
				above_reg <= above_sync_reg[2];
			end
			if (below_sync_reg[2] == below_sync_reg[1]) begin
				below_reg <= below_sync_reg[2];
			end
		end
	end

	// Timer counts phase time from each switching event
	assign blanked    = timer_reg < blank_clks;                  // [R4]
	assign phase_done = (timer_reg + 10'h001) >= slow_clks;

	// Phase transitions
	always_comb begin
		phase_next = phase_reg;
		if (!enable) begin
			phase_next = HCC_IDLE;
		end else begin
			unique case (phase_reg)
				HCC_IDLE: phase_next = HCC_ON;
				HCC_ON: begin
					if (!blanked && above_reg) begin         // [R4] [R12]
						phase_next = HCC_SLOW1;            // [R1]
					end
				end
				HCC_SLOW1: begin
					if (phase_done) begin                    // [R3]
						phase_next = HCC_FAST;
					end
				end
				HCC_FAST: begin
					if (!blanked && below_reg) begin         // [R2] [R12]
						phase_next = HCC_SLOW2;
					end
				end
				HCC_SLOW2: begin
					if (phase_done) begin
						phase_next = HCC_ON;               // [R1]
					end
				end
			endcase
		end
	end

	// Phase register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= HCC_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// Timer restarts on every phase change
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_reg <= '0;
		end else if (phase_next != phase_reg) begin
			timer_reg <= '0;
		end else if (timer_reg != '1) begin
			timer_reg <= timer_reg + 10'h001;
		end
	end

	assign cycle_start_o = enable && (phase_next == HCC_ON)
		&& (phase_reg != HCC_ON);

	// Working hysteresis and its decrementer
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hyst_reg <= '0;
			hysteresis_decrementer_reg <= 4'h0;
		end else if (cycle_start_o) begin
			hyst_reg <= eff_start + eff_end;                   // [R5]
			hysteresis_decrementer_reg <= 4'h0;
		end else if (phase_reg != HCC_IDLE) begin
			hysteresis_decrementer_reg <= hysteresis_decrementer_reg + 4'h1;
			if (hysteresis_decrementer_reg == HYSTERESIS_DECREMENTER_PERIOD && hyst_reg > eff_end) begin
				hyst_reg <= hyst_reg - 6'sd1;              // [R6]
			end
		end
	end
	assign hyst_o = hyst_reg;

	// Bridge drive per phase; idle leaves all switches off
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bridge_o <= '0;
		end else begin
			unique case (phase_next)
				HCC_ON:    bridge_o <= 4'b1001;  // Drive A high, B low
				HCC_FAST:  bridge_o <= 4'b0110;  // Reverse drive
				HCC_SLOW1,
				HCC_SLOW2: bridge_o <= 4'b0101;  // Both low sides
				default:   bridge_o <= 4'b0000;  // Free-wheel [R10]
			endcase
		end
	end
	assign phase_o = phase_reg;

	// Assertions
	a_off_freewheel: assert property ( // [R10]
		!enable |=> bridge_o == 4'b0000)
		else $error("bridge driven while disabled");
	a_mode_select: assert property ( // [R11]
		cfg_i.mode_sel |=> phase_reg == HCC_IDLE)
		else $error("chopper running in other mode");
	a_phase_order: assert property ( // [R1]
		phase_reg == HCC_SLOW1 && phase_next != HCC_SLOW1 && enable
		|-> phase_next == HCC_FAST)
		else $error("slow decay not followed by fast decay");
	a_slow_length: assert property ( // [R3]
		phase_reg == HCC_SLOW2 && phase_next == HCC_ON
		|-> timer_reg + 10'h001 == slow_clks)
		else $error("slow decay length wrong");
	a_on_blanked: assert property ( // [R4]
		phase_reg == HCC_ON && phase_next == HCC_SLOW1
		|-> timer_reg >= blank_clks && above_reg)
		else $error("on phase ended inside blank time");
	a_fast_cmp_end: assert property ( // [R2]
		phase_reg == HCC_FAST && phase_next == HCC_SLOW2
		|-> below_reg && !blanked)
		else $error("fast decay ended without comparator");
	a_hyst_load: assert property ( // [R5]
		cycle_start_o |=> hyst_reg == $past(eff_start + eff_end))
		else $error("hysteresis not loaded at cycle start");
	a_hyst_floor: assert property ( // [R6]
		phase_reg != HCC_IDLE && !cycle_start_o && hyst_reg <= eff_end
		|=> hyst_reg == $past(hyst_reg))
		else $error("hysteresis moved below end value");
	a_hyst_step: assert property ( // [R6]
		!cycle_start_o && phase_reg != HCC_IDLE && hysteresis_decrementer_reg != HYSTERESIS_DECREMENTER_PERIOD
		|=> hyst_reg == $past(hyst_reg))
		else $error("hysteresis stepped off the 16 clock grid");
	a_end_value: assert property ( // [R8]
		eff_end == $signed(HYST_W'(cfg_i.hysteresis_end_value)) - 6'sd3)
		else $error("effective end value wrong");
	a_start_value: assert property ( // [R7]
		eff_start >= 6'sd1)
		else $error("effective start below one");

	c_full_cycle: cover property (
		phase_reg == HCC_SLOW2 && phase_next == HCC_ON);
	c_hyst_dec: cover property (
		phase_reg != HCC_IDLE && $fell(hyst_reg[0]));
	c_fast_end: cover property (
		phase_reg == HCC_FAST && phase_next == HCC_SLOW2);
endmodule
`default_nettype wire

/* testbench/hcc_coil_model.sv */
// Purpose: Coil current and comparator model facing the chopper
// Assumes: Current ramps one unit a clock, target fixed at 40
// Notes:   slow_i holds the below flag back for 64 clocks
`timescale 1ns/10ps
`default_nettype none
module hcc_coil_model
	import hcc_pkg::*;
(
	input  wire logic                     clk_i,   // System clock
	input  wire hcc_bridge_t              br_i,    // Bridge drive
	input  wire logic signed [HYST_W-1:0] hyst_i,  // Working hysteresis
	input  wire logic                     slow_i,  // Late comparator
	output logic                          above_o, // At or above upper
	output logic                          below_o  // At or below lower
);
	int cur = 40; // Coil current
	int dly = 0;  // Clocks spent below
	// Ramp current by bridge state, report both thresholds
	always @(posedge clk_i) begin
		if (br_i == 4'b1001)
			cur <= cur + 1;
		else if (br_i == 4'b0110 && cur > 0)
			cur <= cur - 1;
		dly <= (cur <= 40 - hyst_i) ? dly + 1 : 0;
		above_o <= cur >= 40 + hyst_i;
		below_o <= (cur <= 40 - hyst_i) && (!slow_i || dly >= 64);
	end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the chopper sequencer
// Assumes: Config changed only while the chopper idles
// Notes:   Hysteresis is tracked against clocks since cycle start
`timescale 1ns/10ps
`default_nettype none
module tb;
	import hcc_pkg::*;
	logic                     mclk_i = 1'b0;  // System clock
	logic                     rst_n_i = 1'b0; // Reset, active low
	hcc_cfg_t                 cfg_i = '0;     // Chopper setup
	logic                     slow = 1'b0;    // Late comparator
	logic                     hchk = 1'b0;    // Hysteresis tracking
	logic                     above;          // Upper flag
	logic                     below;          // Lower flag
	hcc_bridge_t              bridge_o;       // Bridge drive
	logic signed [HYST_W-1:0] hyst_o;         // Working hysteresis
	logic                     cycle_start_o;  // Cycle start pulse
	hcc_phase_t               phase_o;        // Phase
	int                       miscompares = 0;
	int                       cmp_count = 0;
	int                       cyc = 0;        // Clocks since cycle start
	int                       hs;             // Expected start
	int                       he;             // Expected end
	int                       n;              // Phase length
	int                       bt[4] = '{16, 24, 36, 54}; // Blank clocks
	always #2 mclk_i = ~mclk_i;
	hcc_chopper DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
		.cmp_above_i(above), .cmp_below_i(below), .bridge_o(bridge_o),
		.hyst_o(hyst_o), .cycle_start_o(cycle_start_o), .phase_o(phase_o));
	hcc_coil_model coil (.clk_i(mclk_i), .br_i(bridge_o), .hyst_i(hyst_o),
		.slow_i(slow), .above_o(above), .below_o(below));
	// Value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Count within bounds
	task automatic rng(input int got, input int lo, input int hi);
		chk(16'(got >= lo && got <= hi), 16'h0001);
	endtask
	// Check phase and drive, then time the phase
	task automatic ph(input hcc_phase_t p, input logic [3:0] br);
		chk(16'(phase_o), 16'(p));
		chk(16'(bridge_o), 16'(br));
		n = 0;
		while (phase_o === p && n < 3000) begin
			@(negedge mclk_i);
			n++;
		end
	endtask
	// Stop the chopper, then load a new setup
	task automatic setup(input hcc_cfg_t c);
		cfg_i.off_time_setting = 4'h0;
		repeat (2) @(negedge mclk_i);
		chk(16'(phase_o), 16'(HCC_IDLE));
		chk(16'(bridge_o), 16'h0000);
		he = int'(c.hysteresis_end_value) - 3;
		hs = int'(c.hysteresis_start_offset) + 1 + he;
		cfg_i = c;
		n = int'(!c.mode_sel && c.off_time_setting != 4'h0);
		#1;
		chk(16'(cycle_start_o), 16'(n));
	endtask
	// One full chopper cycle
	task automatic cyc1(input int t, input int bl, input int lo, input int hi);
		n = 0;
		while (phase_o !== HCC_ON && n < 3000) begin
			@(negedge mclk_i);
			n++;
		end
		ph(HCC_ON, 4'b1001);
		rng(n, bl, bl + 8);
		ph(HCC_SLOW1, 4'b0101);
		chk(16'(n), 16'(12 + 32 * t));
		ph(HCC_FAST, 4'b0110);
		rng(n, lo, hi);
		ph(HCC_SLOW2, 4'b0101);
		chk(16'(n), 16'(12 + 32 * t));
		chk(16'(phase_o), 16'(HCC_ON));
	endtask
	// Verdict
	task wrap_up;
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Clocks since the hysteresis reload
	always @(posedge mclk_i)
		cyc <= cycle_start_o ? 0 : cyc + 1;
	// Hysteresis steps down every 16 clocks to the end value
	always @(negedge mclk_i)
		if (hchk && phase_o !== HCC_IDLE)
			chk(16'(hyst_o), 16'((hs - cyc / 16 < he) ? he
				: hs - cyc / 16));
	// Main sequence
	initial begin
		repeat (16) @(negedge mclk_i);
		rst_n_i = 1'b1;
		hchk = 1'b1;
		setup('{1'b0, 4'h1, 3'h0, 4'h6, 2'h0});
		cyc1(1, 16, 16, 40);
		for (int t = 1; t <= 2; t++) begin
			for (int b = 0; b < 4; b++) begin
				setup('{1'b0, 4'(t), 3'h6, 4'h0, 2'(b)});
				cyc1(t, bt[b], bt[b], 400);
			end
		end
		setup('{1'b0, 4'h1, 3'h0, 4'h6, 2'h0});
		slow = 1'b1;
		cyc1(1, 16, 64, 120);
		slow = 1'b0;
		setup('{1'b1, 4'h3, 3'h0, 4'h0, 2'h0});
		repeat (4) @(negedge mclk_i);
		chk(16'(phase_o), 16'(HCC_IDLE));
		chk(16'(bridge_o), 16'h0000);
		wrap_up;
	end
	// Watchdog
	initial begin
		#80000;
		miscompares++;
		wrap_up;
	end
endmodule
`default_nettype wire
